// ### pkg/bbf_pkg.sv
// Purpose: Shared types and constants for the branch, bit and flag unit.
// Assumes: 8-bit data, 16-bit word program counter, 7-bit branch offset.
// Notes:   Status bit positions follow the usual I T H S V N Z C order.
package bbf_pkg;

    // ------------------------------------------------------------------
    // Widths and status flag positions
    // ------------------------------------------------------------------
    localparam int PC_W      = 16;
    localparam int IO_ADDR_W = 5;
    localparam int FLAG_C    = 0;
    localparam int FLAG_Z    = 1;
    localparam int FLAG_N    = 2;
    localparam int FLAG_V    = 3;
    localparam int FLAG_S    = 4;
    localparam int FLAG_H    = 5;
    localparam int FLAG_T    = 6;
    localparam int FLAG_I    = 7;
    localparam logic [7:0]      FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST    = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP   = 16'h0001;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        op_nop                  = 5'h00,
        branch_same_or_higher   = 5'h01,
        branch_lower            = 5'h02,
        branch_minus            = 5'h03,
        branch_plus             = 5'h04,
        branch_signed_ge        = 5'h05,
        branch_signed_lt        = 5'h06,
        branch_half_carry_set   = 5'h07,
        branch_half_carry_clear = 5'h08,
        branch_transfer_set     = 5'h09,
        branch_transfer_clear   = 5'h0a,
        branch_irq_disabled     = 5'h0b,
        io_bit_set              = 5'h0c,
        io_bit_clear            = 5'h0d,
        shift_left_logical      = 5'h0e,
        shift_right_logical     = 5'h0f,
        rotate_left_carry       = 5'h10,
        rotate_right_carry      = 5'h11,
        shift_right_arith       = 5'h12,
        nibble_swap             = 5'h13,
        bit_to_transfer_flag    = 5'h14,
        transfer_flag_to_bit    = 5'h15,
        flag_set_indexed        = 5'h16,
        flag_clear_indexed      = 5'h17
    } op_code_t;

    // The named single-flag operations map onto the indexed forms.
    typedef enum logic [1:0] {
        st_exec    = 2'b00,
        st_discard = 2'b01,
        st_io_wr   = 2'b10
    } state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        op_code_t             code;
        logic [6:0]           offset;
        logic [2:0]           bit_sel;
        logic [IO_ADDR_W-1:0] io_addr;
        logic [7:0]           reg_val;
        logic [7:0]           io_val;
    } op_t;

    typedef struct packed {
        logic                 reg_we;
        logic [7:0]           reg_data;
        logic                 io_we;
        logic [IO_ADDR_W-1:0] io_addr;
        logic [7:0]           io_data;
    } wb_t;

endpackage : bbf_pkg

// ### core/branch_bit_flag_exec.sv
// Purpose: Executes branches on flags, I/O bit set/clear, shifts, rotates,
//          nibble swap, transfer-flag bit moves and flag set/clear.
// Assumes: Operands arrive already read; one op is offered per cycle.
//          The I/O operand is the current content of the addressed port.
// Notes:   Holds the program counter and the status flags itself.
//          Named single-flag ops arrive as the indexed set/clear forms,
//          with the flag index in the bit select field.
// Contract
// RULE1 - Carry branches: jump PC+k+1, 1/2 cycles
// RULE2 - Minus/plus branches test negative flag
// RULE3 - Signed branches test negative XOR overflow
// RULE4 - Half-carry branches test H, flags untouched
// RULE5 - Transfer-flag branches test T, flags untouched
// RULE6 - Irq-disabled branch taken when I is zero
// RULE7 - IO bit set forces bit, two cycles
// RULE8 - IO bit clear forces bit zero, two cycles
// RULE9 - Left shift inserts zero, updates ZCNV
// RULE10 - Right shift inserts zero, updates ZCNV
// RULE11 - Rotate left through carry, updates flags
// RULE12 - Rotate right through carry, one cycle
// RULE13 - Arithmetic right shift keeps sign bit
// RULE14 - Nibble swap, flags unchanged
// RULE15 - Bit store copies register bit into T
// RULE16 - Bit load copies T into register bit
// RULE17 - Flag set/clear ops, one cycle each
// RULE18 - Signed-test flag set and clear ops
// RULE19 - Branch: one cycle untaken, two taken
`timescale 1ns/100ps

module branch_bit_flag_exec (
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    input  wire logic                         op_valid,
    input  wire bbf_pkg::op_t                 op_in,
    output logic                              op_ready,
    output bbf_pkg::wb_t                      wb_q,
    output logic                              flush_q,
    output logic [bbf_pkg::PC_W-1:0]          pc_q,
    output logic [7:0]                        status_flags_reg
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Sign-extended relative target, plus the step past the branch word.
    function automatic logic [bbf_pkg::PC_W-1:0] rel_target(
        input logic [bbf_pkg::PC_W-1:0] pc,
        input logic [6:0]               k
    );
        logic [bbf_pkg::PC_W-1:0] ext;
        ext = {{(bbf_pkg::PC_W-7){k[6]}}, k};
        return pc + ext + bbf_pkg::PC_STEP;
    endfunction : rel_target

    // Flags after a shift: Z from result, C as given, N from bit 7,
    // V as N xor C. The signed-test flag is left alone.
    function automatic logic [7:0] shift_flags(
        input logic [7:0] f,
        input logic [7:0] res,
        input logic       c
    );
        logic [7:0] o;
        o = f;
        o[bbf_pkg::FLAG_C] = c;
        o[bbf_pkg::FLAG_Z] = (res == 8'h00);
        o[bbf_pkg::FLAG_N] = res[7];
        o[bbf_pkg::FLAG_V] = res[7] ^ c;
        return o;
    endfunction : shift_flags

    // Both I/O bit ops share the two-cycle read-modify-write path.
    function automatic logic is_io_op(
        input bbf_pkg::op_code_t c
    );
        return (c == bbf_pkg::io_bit_set) || (c == bbf_pkg::io_bit_clear);
    endfunction : is_io_op

    // ------------------------------------------------------------------
    // Decode of the offered op
    // ------------------------------------------------------------------
    bbf_pkg::state_t state_q;
    bbf_pkg::state_t state_d;
    logic [7:0]      flags_q;
    logic [7:0]      flags_d;
    logic [7:0]      res;
    logic            res_we;
    logic            is_branch;
    logic            taken;
    logic            fire;
    logic            jump;
    logic            c_f;
    logic            z_f;
    logic            n_f;
    logic            v_f;
    logic            h_f;
    logic            t_f;
    logic            i_f;
    logic [7:0]      io_wdata_q;
    logic [bbf_pkg::IO_ADDR_W-1:0] io_addr_q;

    // ------------------------------------------------------------------
    // Flag views and handshake
    // ------------------------------------------------------------------
    assign c_f = flags_q[bbf_pkg::FLAG_C];
    assign z_f = flags_q[bbf_pkg::FLAG_Z];
    assign n_f = flags_q[bbf_pkg::FLAG_N];
    assign v_f = flags_q[bbf_pkg::FLAG_V];
    assign h_f = flags_q[bbf_pkg::FLAG_H];
    assign t_f = flags_q[bbf_pkg::FLAG_T];
    assign i_f = flags_q[bbf_pkg::FLAG_I];

    // A new op is accepted only in the execute state; the stall states
    // hold the fetch stage off for the second cycle of two-cycle ops.
    assign op_ready         = (state_q == bbf_pkg::st_exec);
    assign fire             = op_valid && op_ready;
    assign status_flags_reg = flags_q;

    // A taken branch redirects the pc and costs one discard cycle.
    assign jump = fire && is_branch && taken;

    // Every op is decoded whether offered or not, so taken is only
    // meaningful together with fire.
    always_comb begin
        is_branch = 1'b1;
        taken     = 1'b0;
        unique case (op_in.code)
            bbf_pkg::branch_same_or_higher:   taken = !c_f; // see RULE1
            bbf_pkg::branch_lower:            taken = c_f; // see RULE1
            bbf_pkg::branch_minus:            taken = n_f; // see RULE2
            bbf_pkg::branch_plus:             taken = !n_f; // see RULE2
            bbf_pkg::branch_signed_ge:        taken = !(n_f ^ v_f); // see RULE3
            bbf_pkg::branch_signed_lt:        taken = n_f ^ v_f; // see RULE3
            bbf_pkg::branch_half_carry_set:   taken = h_f; // see RULE4
            bbf_pkg::branch_half_carry_clear: taken = !h_f; // see RULE4
            bbf_pkg::branch_transfer_set:     taken = t_f; // see RULE5
            bbf_pkg::branch_transfer_clear:   taken = !t_f; // see RULE5
            bbf_pkg::branch_irq_disabled:     taken = !i_f; // see RULE6
            default:                          is_branch = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Register result and flag update
    // ------------------------------------------------------------------
    // The write strobe rises only for ops with a register result, so the
    // data lane may carry a stale operand on every other op.
    always_comb begin
        res     = op_in.reg_val;
        res_we  = 1'b0;
        flags_d = flags_q;
        unique case (op_in.code)
            bbf_pkg::shift_left_logical: begin
                res     = {op_in.reg_val[6:0], 1'b0}; // see RULE9
                res_we  = 1'b1;
                flags_d = shift_flags(flags_q, res, op_in.reg_val[7]);
            end
            bbf_pkg::shift_right_logical: begin
                res     = {1'b0, op_in.reg_val[7:1]}; // see RULE10
                res_we  = 1'b1;
                flags_d = shift_flags(flags_q, res, op_in.reg_val[0]);
            end
            bbf_pkg::rotate_left_carry: begin
                res     = {op_in.reg_val[6:0], c_f}; // see RULE11
                res_we  = 1'b1;
                flags_d = shift_flags(flags_q, res, op_in.reg_val[7]);
            end
            bbf_pkg::rotate_right_carry: begin
                res     = {c_f, op_in.reg_val[7:1]}; // see RULE12
                res_we  = 1'b1;
                flags_d = shift_flags(flags_q, res, op_in.reg_val[0]);
            end
            bbf_pkg::shift_right_arith: begin
                res     = {op_in.reg_val[7], op_in.reg_val[7:1]}; // see RULE13
                res_we  = 1'b1;
                flags_d = shift_flags(flags_q, res, op_in.reg_val[0]);
            end
            bbf_pkg::nibble_swap: begin
                res    = {op_in.reg_val[3:0], op_in.reg_val[7:4]}; // see RULE14
                res_we = 1'b1;
            end
            bbf_pkg::bit_to_transfer_flag: begin
                flags_d[bbf_pkg::FLAG_T] = op_in.reg_val[op_in.bit_sel]; // see RULE15
            end
            bbf_pkg::transfer_flag_to_bit: begin
                res[op_in.bit_sel] = t_f; // see RULE16
                res_we             = 1'b1;
            end
            bbf_pkg::flag_set_indexed: begin
                flags_d[op_in.bit_sel] = 1'b1; // see RULE17 and RULE18
            end
            bbf_pkg::flag_clear_indexed: begin
                flags_d[op_in.bit_sel] = 1'b0; // see RULE17 and RULE18
            end
            default: begin
                res_we = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // Each stall state lasts exactly one cycle. Ready is low in it, so an
    // op offered then waits rather than being lost.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bbf_pkg::st_exec: begin
                if (jump) begin
                    state_d = bbf_pkg::st_discard; // see RULE19
                end else if (fire && is_io_op(op_in.code)) begin
                    state_d = bbf_pkg::st_io_wr; // see RULE7 and RULE8
                end
            end
            bbf_pkg::st_discard: state_d = bbf_pkg::st_exec;
            bbf_pkg::st_io_wr:   state_d = bbf_pkg::st_exec;
            default:             state_d = bbf_pkg::st_exec;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= bbf_pkg::st_exec;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Branches never touch flags; only the ops above change them. The
    // flags also hold through the stall cycles, when nothing is accepted.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= bbf_pkg::FLAGS_RST;
        end else if (fire) begin
            flags_q <= flags_d; // see RULE4 and RULE5
        end
    end

    // ------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------
    // Any other accepted op steps past its own word. The stall cycles
    // leave the pc alone, as no op is taken in them.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= bbf_pkg::PC_RST;
        end else if (jump) begin
            pc_q <= rel_target(pc_q, op_in.offset); // see RULE1
        end else if (fire) begin
            pc_q <= pc_q + bbf_pkg::PC_STEP;
        end
    end

    // The prefetched word after a taken branch is dropped by the fetch
    // stage while this pulse is high.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= jump; // see RULE19
        end
    end

    // ------------------------------------------------------------------
    // I/O read-modify-write: read in cycle one, write in cycle two
    // ------------------------------------------------------------------
    // Captured only for the I/O ops, so other traffic does not toggle
    // the write lane while a write is pending.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_wdata_q <= 8'h00;
            io_addr_q  <= '0;
        end else if (fire && is_io_op(op_in.code)) begin
            io_wdata_q <= op_in.io_val;
            io_addr_q  <= op_in.io_addr;
            if (op_in.code == bbf_pkg::io_bit_set) begin
                io_wdata_q[op_in.bit_sel] <= 1'b1; // see RULE7
            end else if (op_in.code == bbf_pkg::io_bit_clear) begin
                io_wdata_q[op_in.bit_sel] <= 1'b0; // see RULE8
            end
        end
    end

    // ------------------------------------------------------------------
    // Writeback
    // ------------------------------------------------------------------
    // The I/O strobe follows the write state, so it lands two edges after
    // the accept and stays high for one cycle only.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wb_q <= '0;
        end else begin
            wb_q.reg_we   <= fire && res_we;
            wb_q.reg_data <= res;
            wb_q.io_we    <= (state_q == bbf_pkg::st_io_wr);
            wb_q.io_addr  <= io_addr_q;
            wb_q.io_data  <= io_wdata_q;
        end
    end

endmodule : branch_bit_flag_exec

// ### dv/branch_bit_flag_exec_asserts.sv
// Purpose: Concurrent checks on the branch, bit and flag unit ports.
// Assumes: Flags, pc and register write-back change at the edge that accepts an op.
// Notes:   Flag order is I T H S V N Z C, bit 7 down to bit 0.
`timescale 1ns/100ps

module branch_bit_flag_exec_asserts (
    input wire logic                     mclk,
    input wire logic                     nrst,
    input wire logic                     op_valid,
    input wire bbf_pkg::op_t             op_in,
    input wire logic                     op_ready,
    input wire bbf_pkg::wb_t             wb_q,
    input wire logic                     flush_q,
    input wire logic [bbf_pkg::PC_W-1:0] pc_q,
    input wire logic [7:0]               status_flags_reg
);
    // ------------------------------------------------------------------
    // Branch condition worked out from the flags, target from pc and offset
    // ------------------------------------------------------------------
    logic [7:0]  f;
    logic [15:0] tgt;
    logic        acc;
    logic        is_br;
    logic        cond;
    assign f   = status_flags_reg;
    assign acc = op_valid && op_ready;
    assign tgt = pc_q + {{9{op_in.offset[6]}}, op_in.offset} + 16'h0001;
    assign is_br = op_in.code inside {[bbf_pkg::branch_same_or_higher:
                                        bbf_pkg::branch_irq_disabled]};
    always_comb begin
        case (op_in.code)
            bbf_pkg::branch_same_or_higher:   cond = !f[0];
            bbf_pkg::branch_lower:            cond = f[0];
            bbf_pkg::branch_minus:            cond = f[2];
            bbf_pkg::branch_plus:             cond = !f[2];
            bbf_pkg::branch_signed_ge:        cond = !(f[2] ^ f[3]);
            bbf_pkg::branch_signed_lt:        cond = f[2] ^ f[3];
            bbf_pkg::branch_half_carry_set:   cond = f[5];
            bbf_pkg::branch_half_carry_clear: cond = !f[5];
            bbf_pkg::branch_transfer_set:     cond = f[6];
            bbf_pkg::branch_transfer_clear:   cond = !f[6];
            bbf_pkg::branch_irq_disabled:     cond = !f[7];
            default:                          cond = 1'b0;
        endcase
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    chk_branch_taken: assert property (
        acc && is_br && cond |=> flush_q && !op_ready &&
        pc_q == $past(tgt) && $stable(status_flags_reg))
        else $error("taken branch target or flush wrong");
    chk_branch_skip: assert property (
        acc && is_br && !cond |=> !flush_q && op_ready &&
        pc_q == $past(pc_q) + 16'h0001)
        else $error("untaken branch did not step by one");
    chk_flush_pulse: assert property (
        flush_q |=> !flush_q && op_ready)
        else $error("discard cycle longer than one");
    chk_io_set_write: assert property (
        acc && op_in.code == bbf_pkg::io_bit_set |=> !op_ready ##1
        wb_q.io_we && wb_q.io_addr == $past(op_in.io_addr, 2) &&
        wb_q.io_data == ($past(op_in.io_val, 2) |
                         (8'h01 << $past(op_in.bit_sel, 2))))
        else $error("io bit set write wrong");
    chk_shl_result: assert property (
        acc && op_in.code == bbf_pkg::shift_left_logical |=> wb_q.reg_we &&
        wb_q.reg_data == {$past(op_in.reg_val[6:0]), 1'b0} &&
        f[0] == $past(op_in.reg_val[7]))
        else $error("left shift result wrong");
    chk_ror_result: assert property (
        acc && op_in.code == bbf_pkg::rotate_right_carry |=>
        wb_q.reg_data == {$past(f[0]), $past(op_in.reg_val[7:1])} &&
        f[0] == $past(op_in.reg_val[0]))
        else $error("rotate right result wrong");
    chk_swap_flags: assert property (
        acc && op_in.code == bbf_pkg::nibble_swap |=> wb_q.reg_we &&
        wb_q.reg_data == {$past(op_in.reg_val[3:0]),
                          $past(op_in.reg_val[7:4])} && $stable(f))
        else $error("nibble swap wrong");
    chk_bst_tflag: assert property (
        acc && op_in.code == bbf_pkg::bit_to_transfer_flag |=>
        f[6] == $past(op_in.reg_val[op_in.bit_sel]) &&
        {f[7], f[5:0]} == $past({f[7], f[5:0]}))
        else $error("bit store to transfer flag wrong");
    chk_flag_set_idx: assert property (
        acc && op_in.code == bbf_pkg::flag_set_indexed |=>
        f == ($past(f) | (8'h01 << $past(op_in.bit_sel))))
        else $error("indexed flag set wrong");
endmodule : branch_bit_flag_exec_asserts

bind branch_bit_flag_exec branch_bit_flag_exec_asserts chk_u (
    .mclk(mclk), .nrst(nrst), .op_valid(op_valid), .op_in(op_in),
    .op_ready(op_ready), .wb_q(wb_q), .flush_q(flush_q), .pc_q(pc_q),
    .status_flags_reg(status_flags_reg));

// ### dv/branch_bit_flag_exec_tb.sv
// Purpose: Self-checking bench for the branch, bit and flag unit.
// Assumes: Every accepted op steps the pc by one unless a branch is taken.
// Notes:   Inputs move on the falling edge, results are read there too.
`timescale 1ns/100ps

module branch_bit_flag_exec_tb;
    logic               mclk;
    logic               nrst;
    logic               op_valid;
    logic               op_ready;
    logic               flush_q;
    bbf_pkg::op_t       op_in;
    bbf_pkg::wb_t       wb_q;
    logic [15:0]        pc_q;
    logic [15:0]        exp_pc;
    logic [7:0]         status_flags_reg;
    logic [7:0]         exp_f;
    int                 errors;
    int                 samples_checked;
    int                 cycles;

    always #2 mclk = ~mclk;

    branch_bit_flag_exec dut_u (
        .mclk(mclk), .nrst(nrst), .op_valid(op_valid), .op_in(op_in),
        .op_ready(op_ready), .wb_q(wb_q), .flush_q(flush_q), .pc_q(pc_q),
        .status_flags_reg(status_flags_reg));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Waits for ready, offers one op, and returns in the cycle after it.
    task automatic issue(input bbf_pkg::op_code_t c, input logic [6:0] k,
                         input logic [2:0] b, input logic [7:0] r,
                         input logic [7:0] io);
        int n = 0;
        @(negedge mclk);
        while (op_ready !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        op_in = '{code: c, offset: k, bit_sel: b, io_addr: 5'h13,
                  reg_val: r, io_val: io};
        op_valid = 1'b1;
        @(negedge mclk);
        op_valid = 1'b0;
        exp_pc = exp_pc + 16'h0001;
    endtask : issue

    task automatic put_flag(input int i, input logic v);
        issue(v ? bbf_pkg::flag_set_indexed : bbf_pkg::flag_clear_indexed,
              7'h00, i[2:0], 8'h00, 8'h00);
        exp_f[i] = v;
        cmp(status_flags_reg, exp_f);
    endtask : put_flag

    task automatic br(input int c, input logic [6:0] k, input logic tk);
        issue(bbf_pkg::op_code_t'(c), k, 3'h0, 8'h00, 8'h00);
        if (tk) begin
            exp_pc = exp_pc + {{9{k[6]}}, k};
        end
        cmp(pc_q, exp_pc);
        cmp({flush_q, op_ready}, {tk, !tk});
        cmp(status_flags_reg, exp_f);
    endtask : br

    task automatic io(input bbf_pkg::op_code_t c, input logic [2:0] b,
                      input logic [7:0] v, input logic [7:0] res);
        issue(c, 7'h00, b, 8'h00, v);
        cmp({op_ready, wb_q.io_we}, 16'h0000);
        @(negedge mclk);
        cmp({wb_q.io_we, wb_q.io_addr}, {1'b1, 5'h13});
        cmp(wb_q.io_data, res);
        cmp(status_flags_reg, exp_f);
    endtask : io

    task automatic sh(input bbf_pkg::op_code_t c, input logic [7:0] r,
                      input logic [7:0] res, input logic cy);
        issue(c, 7'h00, 3'h0, r, 8'h00);
        if (c != bbf_pkg::nibble_swap) begin
            exp_f[3:0] = {res[7] ^ cy, res[7], res == 8'h00, cy};
        end
        cmp({wb_q.reg_we, wb_q.reg_data}, {1'b1, res});
        cmp(status_flags_reg, exp_f);
    endtask : sh

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_branches;
        int fi [11] = '{0, 0, 2, 2, 2, 2, 5, 5, 6, 6, 7};
        logic want [11] = '{0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 0};
        for (int i = 0; i < 11; i++) begin
            for (int v = 0; v < 2; v++) begin
                put_flag(fi[i], v[0]);
                br(i + 1, {i[0], 6'h05}, v[0] == want[i]);
            end
        end
        put_flag(3, 1'b1);
        put_flag(2, 1'b1);
        br(5, 7'h40, 1'b1);
        br(6, 7'h3f, 1'b0);
        put_flag(3, 1'b0);
    endtask : t_branches

    task automatic t_bits;
        issue(bbf_pkg::bit_to_transfer_flag, 7'h00, 3'h4, 8'hef, 8'h00);
        exp_f[6] = 1'b0;
        cmp(status_flags_reg, exp_f);
        issue(bbf_pkg::transfer_flag_to_bit, 7'h00, 3'h2, 8'hff, 8'h00);
        cmp(wb_q.reg_data, 8'hfb);
        issue(bbf_pkg::bit_to_transfer_flag, 7'h00, 3'h4, 8'h10, 8'h00);
        exp_f[6] = 1'b1;
        cmp(status_flags_reg, exp_f);
        issue(bbf_pkg::transfer_flag_to_bit, 7'h00, 3'h7, 8'h00, 8'h00);
        cmp(wb_q.reg_data, 8'h80);
        cmp(status_flags_reg, exp_f);
    endtask : t_bits

    task automatic tally_and_finish;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // A hung handshake would otherwise stall the run for ever.
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 4000) begin
            errors++;
            tally_and_finish;
        end
    end

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        op_valid = 1'b0;
        op_in = '0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        exp_pc = 16'h0000;
        exp_f = 8'h00;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        cmp(pc_q, exp_pc);
        cmp({status_flags_reg, op_ready, flush_q}, 16'h0002);
        for (int i = 0; i < 8; i++) put_flag(i, 1'b1);
        for (int i = 7; i >= 0; i--) put_flag(i, 1'b0);
        t_branches;
        io(bbf_pkg::io_bit_set, 3'h0, 8'h5a, 8'h5b);
        io(bbf_pkg::io_bit_clear, 3'h6, 8'h5a, 8'h1a);
        cmp(pc_q, exp_pc);
        sh(bbf_pkg::shift_left_logical, 8'h80, 8'h00, 1'b1);
        sh(bbf_pkg::shift_right_logical, 8'h96, 8'h4b, 1'b0);
        sh(bbf_pkg::rotate_left_carry, 8'h96, 8'h2c, 1'b1);
        sh(bbf_pkg::rotate_right_carry, 8'h96, 8'hcb, 1'b0);
        sh(bbf_pkg::shift_right_arith, 8'h81, 8'hc0, 1'b1);
        sh(bbf_pkg::rotate_left_carry, 8'h01, 8'h03, 1'b0);
        sh(bbf_pkg::nibble_swap, 8'h96, 8'h69, 1'b0);
        t_bits;
        cmp(pc_q, exp_pc);
        tally_and_finish;
    end
endmodule : branch_bit_flag_exec_tb
